//--- include/jk_pair_defines.vh
`ifndef JK_PAIR_DEFINES_VH
`define JK_PAIR_DEFINES_VH

`define JK_SYNC_STAGES   2
`define JK_STATE_RST     1'b0
`define JK_PIN_CLK_RST   1'b0
`define JK_PIN_ASYNC_RST 1'b1
`define JK_PIN_DATA_RST  1'b0

`endif

//--- rtl/jk_pin_sync.v
`timescale 1ns/1ns
// Two-stage synchroniser; the first stage feeds only the second
module jk_pin_sync #(
  parameter             WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk_sys_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= RST_VAL;
      stable <= RST_VAL;
    end else begin
      meta   <= pin_i;
      stable <= meta;
    end
  end

  assign sync_o = stable;
endmodule

//--- rtl/dual_jk_flip_flop.v
`timescale 1ns/1ns
`include "jk_pair_defines.vh"
// Pins are asynchronous to clk_sys_i, so every one is synchronised first.
// The price is a fixed latency of three system clocks from pin to output,
// and the pin clock must stay high and low for at least two system clocks.
// Both force pins low leaves the stored bit alone, so releasing both in
// one cycle brings the old value back.
module dual_jk_flip_flop #(
  parameter CHANNELS = 2
) (
  input  wire clk_sys_i,
  input  wire rst_n_i,
  input  wire ch0_edge_i,
  input  wire ch0_j_i,
  input  wire ch0_k_i,
  input  wire ch0_async_one_low_i,
  input  wire ch0_async_zero_low_i,
  output wire ch0_q_o,
  output wire ch0_q_n_o,
  input  wire ch1_edge_i,
  input  wire ch1_j_i,
  input  wire ch1_k_i,
  input  wire ch1_async_one_low_i,
  input  wire ch1_async_zero_low_i,
  output wire ch1_q_o,
  output wire ch1_q_n_o
);
  wire [CHANNELS-1:0] edge_pin;
  wire [CHANNELS-1:0] j_pin;
  wire [CHANNELS-1:0] k_pin;
  wire [CHANNELS-1:0] one_pin;
  wire [CHANNELS-1:0] zero_pin;
  wire [CHANNELS-1:0] edge_s;
  wire [CHANNELS-1:0] j_s;
  wire [CHANNELS-1:0] k_s;
  wire [CHANNELS-1:0] one_s;
  wire [CHANNELS-1:0] zero_s;
  reg  [CHANNELS-1:0] edge_d;
  reg  [CHANNELS-1:0] state;
  reg  [CHANNELS-1:0] q;
  reg  [CHANNELS-1:0] q_n;
  reg  [CHANNELS-1:0] next_state;
  reg  [CHANNELS-1:0] next_q_n;
  wire [CHANNELS-1:0] fall;
  wire [CHANNELS-1:0] both_low;
  wire [CHANNELS-1:0] next_q;

  // Lane 0 sits in bit 0 of every packed pin vector
  assign edge_pin = {ch1_edge_i, ch0_edge_i};
  assign j_pin    = {ch1_j_i, ch0_j_i};
  assign k_pin    = {ch1_k_i, ch0_k_i};
  assign one_pin  = {ch1_async_one_low_i, ch0_async_one_low_i};
  assign zero_pin = {ch1_async_zero_low_i, ch0_async_zero_low_i};

  // Clock pin resets low; a rise out of reset is never taken for a fall
  jk_pin_sync #(
    .WIDTH   (CHANNELS),
    .RST_VAL ({CHANNELS{`JK_PIN_CLK_RST}})
  ) u_sync_edge (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (edge_pin),
    .sync_o    (edge_s)
  );

  jk_pin_sync #(
    .WIDTH   (CHANNELS),
    .RST_VAL ({CHANNELS{`JK_PIN_DATA_RST}})
  ) u_sync_j (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (j_pin),
    .sync_o    (j_s)
  );

  jk_pin_sync #(
    .WIDTH   (CHANNELS),
    .RST_VAL ({CHANNELS{`JK_PIN_DATA_RST}})
  ) u_sync_k (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (k_pin),
    .sync_o    (k_s)
  );

  // Force pins reset inactive so leaving reset forces nothing
  jk_pin_sync #(
    .WIDTH   (CHANNELS),
    .RST_VAL ({CHANNELS{`JK_PIN_ASYNC_RST}})
  ) u_sync_one (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (one_pin),
    .sync_o    (one_s)
  );

  jk_pin_sync #(
    .WIDTH   (CHANNELS),
    .RST_VAL ({CHANNELS{`JK_PIN_ASYNC_RST}})
  ) u_sync_zero (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (zero_pin),
    .sync_o    (zero_s)
  );

  // Force pin decode, one-hot by priority; zero means no force is active
  localparam [2:0] FORCE_NONE = 3'h0;
  localparam [2:0] FORCE_ZERO = 3'h1;
  localparam [2:0] FORCE_ONE  = 3'h2;
  localparam [2:0] FORCE_BOTH = 3'h4;

  // J and K as sampled at an active fall, J in the upper bit
  localparam [1:0] JK_HOLD    = 2'h0;
  localparam [1:0] JK_ZERO    = 2'h1;
  localparam [1:0] JK_ONE     = 2'h2;
  localparam [1:0] JK_TOGGLE  = 2'h3;

  function [2:0] force_mode;
    input one_low;
    input zero_low;
    begin
      case ({one_low, zero_low})
        2'h0:    force_mode = FORCE_BOTH;
        2'h1:    force_mode = FORCE_ONE;
        2'h2:    force_mode = FORCE_ZERO;
        default: force_mode = FORCE_NONE;
      endcase
    end
  endfunction

  // Falling edge of a synchronised pin clock
  function fell;
    input prev_lvl;
    input cur_lvl;
    begin
      fell = prev_lvl & ~cur_lvl;
    end
  endfunction

  // Stored value after an active falling edge
  function jk_clocked;
    input cur;
    input j;
    input k;
    begin
      case ({j, k})
        JK_ONE:    jk_clocked = 1'b1;
        JK_ZERO:   jk_clocked = 1'b0;
        JK_TOGGLE: jk_clocked = ~cur;
        JK_HOLD:   jk_clocked = cur;
        default:   jk_clocked = cur;
      endcase
    end
  endfunction

  // Next value of one stage from its synchronised pins
  function [1:0] jk_next;
    input cur;
    input one_low;
    input zero_low;
    input fall_seen;
    input j;
    input k;
    begin
      jk_next = {cur, ~cur};
      case (force_mode(one_low, zero_low))
        FORCE_BOTH: jk_next = {cur, 1'b1};
        FORCE_ONE:  jk_next = 2'h2;
        FORCE_ZERO: jk_next = 2'h1;
        default: begin
          if (fall_seen) begin
            jk_next = {jk_clocked(cur, j, k), ~jk_clocked(cur, j, k)};
          end else begin
            jk_next = {cur, ~cur};
          end
        end
      endcase
    end
  endfunction

  // Each lane is a separate stage sharing nothing but the system clock and reset
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : lane
      assign fall[g]     = fell(edge_d[g], edge_s[g]);
      assign both_low[g] = (force_mode(one_s[g], zero_s[g]) == FORCE_BOTH);
      // Both outputs high only while both force pins are low
      assign next_q[g]   = next_state[g] | both_low[g];

      always @* begin
        {next_state[g], next_q_n[g]} = jk_next(state[g], one_s[g],
                                               zero_s[g], fall[g],
                                               j_s[g], k_s[g]);
      end

      // Edge history and stored state
      always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          edge_d[g] <= `JK_PIN_CLK_RST;
          state[g]  <= `JK_STATE_RST;
        end else begin
          edge_d[g] <= edge_s[g];
          state[g]  <= next_state[g];
        end
      end

      // Outputs are flopped so both pins move on the same clock edge
      always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          q[g]   <= `JK_STATE_RST;
          q_n[g] <= ~`JK_STATE_RST;
        end else begin
          q[g]   <= next_q[g];
          q_n[g] <= next_q_n[g];
        end
      end
    end
  endgenerate

  assign ch0_q_o   = q[0];
  assign ch0_q_n_o = q_n[0];
  assign ch1_q_o   = q[1];
  assign ch1_q_n_o = q_n[1];
endmodule

//--- tb/dual_jk_checker.sv
`timescale 1ns/1ns
module dual_jk_checker (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ch0_edge_i,
  input wire ch0_j_i,
  input wire ch0_k_i,
  input wire ch0_async_one_low_i,
  input wire ch0_async_zero_low_i,
  input wire ch0_q_o,
  input wire ch0_q_n_o,
  input wire ch1_edge_i,
  input wire ch1_j_i,
  input wire ch1_k_i,
  input wire ch1_async_one_low_i,
  input wire ch1_async_zero_low_i,
  input wire ch1_q_o,
  input wire ch1_q_n_o
);
  // Pin to output is three samples: two sync flops, then the output flop
  wire o0 = ch0_async_one_low_i, z0 = ch0_async_zero_low_i, e0 = ch0_edge_i;
  wire q0 = ch0_q_o, n0 = ch0_q_n_o, q1 = ch1_q_o, e1 = ch1_edge_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_one; $past(!o0 && z0, 3) |-> q0 && !n0; endproperty
  a_one: assert property (p_one) else $error("force one");
  property p_zero; $past(o0 && !z0, 3) |-> !q0 && n0; endproperty
  a_zero: assert property (p_zero) else $error("force zero");
  property p_both; $past(!o0 && !z0, 3) |-> q0 && n0; endproperty
  a_both: assert property (p_both) else $error("both low");
  property p_jk; $past(e0, 4) && !$past(e0, 3) && $past(o0 && z0, 3) |->
    q0 == ($past(ch0_j_i, 3) && !$past(q0) || !$past(ch0_k_i, 3) && $past(q0));
  endproperty
  a_jk: assert property (p_jk) else $error("jk update");
  property p_hold; $past(o0 && z0, 3) && $past(o0 && z0, 4) &&
    !($past(e0, 4) && !$past(e0, 3)) |-> $stable(q0) && $stable(n0);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_inv; !$past(!o0 && !z0, 3) |-> n0 == !q0; endproperty
  a_inv: assert property (p_inv) else $error("complement");
  property p_jk1; $past(e1, 4) && !$past(e1, 3) &&
    $past(ch1_async_one_low_i && ch1_async_zero_low_i, 3) |->
    q1 == ($past(ch1_j_i, 3) && !$past(q1) || !$past(ch1_k_i, 3) && $past(q1));
  endproperty
  a_jk1: assert property (p_jk1) else $error("ch1 jk update");
  property p_one1; $past(!ch1_async_one_low_i, 3) |-> q1; endproperty
  a_one1: assert property (p_one1) else $error("ch1 force one");
  c_both: cover property ($past(!o0 && !z0, 3));
  c_tog: cover property ($fell(e0) && ch0_j_i && ch0_k_i);
  c_one1: cover property ($past(!ch1_async_one_low_i, 3));
endmodule
bind dual_jk_flip_flop dual_jk_checker u_chk (.*);

//--- tb/jk_pin_driver.sv
`timescale 1ns/1ns
module jk_pin_driver (
  input  wire clk_sys_i,
  input  wire fire_i,
  output wire pin_o
);
  // Stage clock stands high between pulses; five cycles low per fire
  reg [2:0] n = 3'h0;
  always @(posedge clk_sys_i) begin
    n <= fire_i ? 3'h5 : n - {2'h0, n != 3'h0};
  end
  assign #1 pin_o = n == 3'h0;
endmodule

//--- tb/dual_jk_flip_flop_tb_top.sv
`timescale 1ns/1ns
module dual_jk_flip_flop_tb_top;
  reg clk_sys_i = 1'b0, rst_n_i = 1'b0, fire = 1'b0;
  reg ch0_j_i = 1'b0, ch0_k_i = 1'b0, ch1_j_i = 1'b0, ch1_k_i = 1'b0;
  reg ch0_async_one_low_i = 1'b1, ch0_async_zero_low_i = 1'b1;
  reg ch1_async_one_low_i = 1'b1, ch1_async_zero_low_i = 1'b1;
  wire ch0_edge_i, ch1_edge_i, ch0_q_o, ch0_q_n_o, ch1_q_o, ch1_q_n_o;
  wire [3:0] seen_word = {ch1_q_o, ch1_q_n_o, ch0_q_o, ch0_q_n_o};
  reg [31:0] r = 32'hfc2d, b;
  reg [3:0] e;
  reg [1:0] st = 2'h0;
  logic [3:0] q_exp[$];
  integer err_count = 0, samples_checked = 0, i, c;
  event chk;
  dual_jk_flip_flop DUT (.*);
  jk_pin_driver u_p0 (
    .clk_sys_i (clk_sys_i),
    .fire_i    (fire),
    .pin_o     (ch0_edge_i)
  );
  jk_pin_driver u_p1 (
    .clk_sys_i (clk_sys_i),
    .fire_i    (fire),
    .pin_o     (ch1_edge_i)
  );
  initial forever #20 clk_sys_i = ~clk_sys_i;
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task check(input [3:0] seen, input [3:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial forever begin
    @chk;
    check(seen_word, q_exp.pop_front());
  end
  initial begin
    #400000;
    err_count = err_count + 1;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    for (i = 0; i < 300; i = i + 1) begin
      r = xs(r);
      @(posedge clk_sys_i) #1;
      {ch1_async_zero_low_i, ch1_async_one_low_i, ch1_k_i, ch1_j_i,
       ch0_async_zero_low_i, ch0_async_one_low_i, ch0_k_i, ch0_j_i} =
        {~&r[15:13], ~&r[12:10], r[9:8], ~&r[7:5], ~&r[4:2], r[1:0]};
      for (c = 0; c < 2; c = c + 1) begin
        b = r >> (8 * c);
        // While both force pins are low the stored state is left alone
        if (&b[4:2] && &b[7:5]) e[2*c+:2] = 2'b11;
        else begin
          st[c] = &b[4:2] ? 1'b1 : &b[7:5] ? 1'b0 :
                  b[0] & ~st[c] | ~b[1] & st[c];
          e[2*c+:2] = {st[c], ~st[c]};
        end
      end
      repeat (2) @(posedge clk_sys_i);
      #1 fire = 1'b1;
      @(posedge clk_sys_i);
      #1 fire = 1'b0;
      repeat (9) @(posedge clk_sys_i);
      #1 q_exp.push_back(e);
      -> chk;
    end
    $display("test random_steps done");
    @(posedge clk_sys_i);
    wrap_up;
  end
endmodule
